// ==== core/ssd_consts.vh ====
// Constants of the six-switch driver serial control block
`ifndef SSD_CONSTS_VH
`define SSD_CONSTS_VH

// ==========================================
// Control word fields
`define SSD_CTL_CLEAR       0
`define SSD_CTL_SW_LO       1
`define SSD_CTL_SW_HI       6
`define SSD_CTL_OLD_N       13
`define SSD_CTL_DELAY_SEL   14
`define SSD_CTL_RUN         15
`define SSD_CTL_RESET       16'hE000
`define SSD_CTL_USED_MASK   16'hE07F

// ==========================================
// Status word fields
`define SSD_ST_PREWARN      0
`define SSD_ST_SHORT        13
`define SSD_ST_STANDBY      14
`define SSD_ST_SUPPLY_FAIL  15
`define SSD_ST_ALL_HIGH     16'hFFFF

// ==========================================
// Word length
`define SSD_WORD_BITS       16
`define SSD_BITCNT_W        5

// ==========================================
// Timing, clock period in ns and delays in us
`define SSD_CLK_NS          100
`define SSD_OV_LONG_US      14000
`define SSD_OV_SHORT_US     3500
`define SSD_SC_LONG_US      100000
`define SSD_SC_SHORT_US     12500

`endif

// ==== core/ssd_serial_ctrl.v ====
// Serial control and status logic of the six-switch driver
`include "ssd_consts.vh"

module ssd_serial_ctrl
#(
	parameter OV_LONG_CYC  = (`SSD_OV_LONG_US * 1000) / `SSD_CLK_NS,
	parameter OV_SHORT_CYC = (`SSD_OV_SHORT_US * 1000) / `SSD_CLK_NS,
	parameter SC_LONG_CYC  = (`SSD_SC_LONG_US * 1000) / `SSD_CLK_NS,
	parameter SC_SHORT_CYC = (`SSD_SC_SHORT_US * 1000) / `SSD_CLK_NS
)
(
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        chip_select_n,
	input  wire        serial_clk,
	input  wire        serial_data_in,
	output reg         serial_data_out,
	output reg         serial_data_oe,
	input  wire        standby_pin_n,
	input  wire        temp_prewarn,
	input  wire        temp_shutdown,
	input  wire        supply_fault,
	input  wire [5:0]  short_current,
	input  wire [5:0]  open_load_cmp,
	output reg  [5:0]  switch_on,
	output reg  [5:0]  open_load_current,
	output reg  [1:0]  shutdown_delay_select
);

	// ==========================================
	// Input synchronisers
	// Two stages on every pin input
	reg  [1:0]  cs_sync_ff;
	reg  [1:0]  sck_sync_ff;
	reg  [1:0]  din_sync_ff;
	reg  [1:0]  inh_sync_ff;
	reg  [1:0]  tpw_sync_ff;
	reg  [1:0]  tsd_sync_ff;
	reg  [1:0]  vsf_sync_ff;
	reg  [5:0]  sc_meta_ff;
	reg  [5:0]  sc_sync_ff;
	reg  [5:0]  ol_meta_ff;
	reg  [5:0]  ol_sync_ff;
	reg         cs_prev_ff;
	reg         sck_prev_ff;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			cs_sync_ff  <= 2'b11;
			sck_sync_ff <= 2'b00;
			din_sync_ff <= 2'b00;
			inh_sync_ff <= 2'b00;
			tpw_sync_ff <= 2'b00;
			tsd_sync_ff <= 2'b00;
			vsf_sync_ff <= 2'b00;
			sc_meta_ff  <= 6'h00;
			sc_sync_ff  <= 6'h00;
			ol_meta_ff  <= 6'h00;
			ol_sync_ff  <= 6'h00;
			cs_prev_ff  <= 1'b1;
			sck_prev_ff <= 1'b0;
		end
		else
		begin
			cs_sync_ff  <= {cs_sync_ff[0], chip_select_n};
			sck_sync_ff <= {sck_sync_ff[0], serial_clk};
			din_sync_ff <= {din_sync_ff[0], serial_data_in};
			inh_sync_ff <= {inh_sync_ff[0], standby_pin_n};
			tpw_sync_ff <= {tpw_sync_ff[0], temp_prewarn};
			tsd_sync_ff <= {tsd_sync_ff[0], temp_shutdown};
			vsf_sync_ff <= {vsf_sync_ff[0], supply_fault};
			sc_meta_ff  <= short_current;
			sc_sync_ff  <= sc_meta_ff;
			ol_meta_ff  <= open_load_cmp;
			ol_sync_ff  <= ol_meta_ff;
			cs_prev_ff  <= cs_sync_ff[1];
			sck_prev_ff <= sck_sync_ff[1];
		end
	end

	wire cs_n    = cs_sync_ff[1];
	wire cs_fall = cs_prev_ff & ~cs_n;
	wire cs_rise = ~cs_prev_ff & cs_n;
	wire sck_fall = sck_prev_ff & ~sck_sync_ff[1];
	wire sck_rise = ~sck_prev_ff & sck_sync_ff[1];

	// ==========================================
	// Delay loads cut to counter width
	localparam [23:0] OV_LONG_LD  = OV_LONG_CYC[23:0];
	localparam [23:0] OV_SHORT_LD = OV_SHORT_CYC[23:0];
	localparam [23:0] SC_LONG_LD  = SC_LONG_CYC[23:0];
	localparam [23:0] SC_SHORT_LD = SC_SHORT_CYC[23:0];

	// ==========================================
	// Decoding helpers
	// Open-load mode needs the run bit high
	function ol_mode;
		input [15:0] ctl;
		begin
			ol_mode = ~ctl[`SSD_CTL_OLD_N] & ctl[`SSD_CTL_RUN];
		end
	endfunction

	// Delay load value by select bit
	function [23:0] pick_delay;
		input        long_sel;
		input [23:0] long_cyc;
		input [23:0] short_cyc;
		begin
			if (long_sel)
				pick_delay = long_cyc;
			else
				pick_delay = short_cyc;
		end
	endfunction

	// ==========================================
	// Control and status registers
	reg  [15:0] ctl_ff;
	reg  [15:0] shift_in_ff;
	reg  [15:0] shift_out_ff;
	reg  [4:0]  bit_cnt_ff;
	reg         supply_fail_ff;
	reg         short_detected_ff;
	reg  [5:0]  short_off_ff;
	reg         overtemp_ff;
	reg  [23:0] uv_cnt_ff;
	reg  [5:0]  sc_done;
	reg  [15:0] status_word;
	reg  [15:0] nxt_status;

	wire apply_word = cs_rise & (bit_cnt_ff >= 5'd16);
	wire clear_req  = apply_word & shift_in_ff[`SSD_CTL_CLEAR];
	wire standby_flag = ~ctl_ff[`SSD_CTL_RUN] | ~inh_sync_ff[1];
	wire supply_off   = (uv_cnt_ff == 24'h00_0000) & vsf_sync_ff[1];
	// Any of these forces all six switch_on bits off
	wire outputs_blocked = standby_flag | supply_off | overtemp_ff;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctl_ff <= `SSD_CTL_RESET;
			shift_in_ff <= 16'h0000;
			shift_out_ff <= 16'h0000;
			bit_cnt_ff <= 5'h00;
		end
		else
		begin
			if (cs_fall)
			begin
				bit_cnt_ff <= 5'h00;
				shift_out_ff <= status_word;
			end
			else if (~cs_n & sck_fall)
			begin
				shift_in_ff <= {din_sync_ff[1], shift_in_ff[15:1]};
				if (bit_cnt_ff != 5'd16)
					bit_cnt_ff <= bit_cnt_ff + 5'd1;
			end
			else if (~cs_n & sck_rise & (bit_cnt_ff != 5'h00))
				shift_out_ff <= {1'b0, shift_out_ff[15:1]};
			if (apply_word)
				ctl_ff <= shift_in_ff & `SSD_CTL_USED_MASK;
		end
	end

	// ==========================================
	// Output pin driver
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
		end
		else
		begin
			serial_data_oe <= ~cs_n;
			if (cs_fall)
				serial_data_out <= status_word[`SSD_ST_PREWARN];
			else if (~cs_n & sck_rise & (bit_cnt_ff != 5'h00))
				serial_data_out <= shift_out_ff[1];
		end
	end

	// ==========================================
	// Supply fail and short timers
	reg  [23:0] sc_cnt_ff [0:5];
	integer i;
	integer j;

	// Short expiry per output
	always @*
	begin
		sc_done = 6'h00;
		for (j = 0; j < 6; j = j + 1)
		begin
			// Prewarn ends the short delay at once
			sc_done[j] = sc_sync_ff[j] & switch_on[j]
				& ((sc_cnt_ff[j] == 24'h00_0000) | tpw_sync_ff[1]);
		end
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			uv_cnt_ff <= 24'h00_0000;
			supply_fail_ff <= 1'b0;
			short_detected_ff <= 1'b0;
			short_off_ff <= 6'h00;
			overtemp_ff <= 1'b0;
			for (i = 0; i < 6; i = i + 1)
				sc_cnt_ff[i] <= 24'h00_0000;
		end
		else
		begin
			// supply fault delay by select bit
			if (~vsf_sync_ff[1])
				uv_cnt_ff <= pick_delay(ctl_ff[`SSD_CTL_DELAY_SEL], OV_LONG_LD,
					OV_SHORT_LD);
			else if (uv_cnt_ff != 24'h00_0000)
				uv_cnt_ff <= uv_cnt_ff - 24'h00_0001;
			if (supply_off)
				supply_fail_ff <= 1'b1;
			else if (clear_req)
				supply_fail_ff <= 1'b0;
			for (i = 0; i < 6; i = i + 1)
			begin
				if (~sc_sync_ff[i] | ~switch_on[i])
					sc_cnt_ff[i] <= pick_delay(ctl_ff[`SSD_CTL_DELAY_SEL], SC_LONG_LD,
						SC_SHORT_LD);
				else if (sc_cnt_ff[i] != 24'h00_0000)
					sc_cnt_ff[i] <= sc_cnt_ff[i] - 24'h00_0001;
			end
			if (|sc_done)
			begin
				short_detected_ff <= 1'b1;
				short_off_ff <= short_off_ff | sc_done;
			end
			else if (clear_req)
			begin
				short_detected_ff <= 1'b0;
				short_off_ff <= 6'h00;
			end
			// overtemp held until cool and cleared
			if (tsd_sync_ff[1])
				overtemp_ff <= 1'b1;
			else if (clear_req)
				overtemp_ff <= 1'b0;
		end
	end

	// ==========================================
	// Output stages and status word
	always @*
	begin
		nxt_status = 16'h0000;
		nxt_status[`SSD_ST_PREWARN] = tpw_sync_ff[1];
		if (ol_mode(ctl_ff))
			nxt_status[6:1] = (switch_on & ~open_load_current) | (ol_sync_ff
				& open_load_current);
		else
			nxt_status[6:1] = switch_on;
		nxt_status[`SSD_ST_SHORT] = short_detected_ff;
		nxt_status[`SSD_ST_STANDBY] = standby_flag;
		nxt_status[`SSD_ST_SUPPLY_FAIL] = supply_fail_ff;
		status_word = overtemp_ff ? `SSD_ST_ALL_HIGH : nxt_status;
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			switch_on <= 6'h00;
			open_load_current <= 6'h00;
			shutdown_delay_select <= 2'b11;
		end
		else
		begin
			if (outputs_blocked)
				switch_on <= 6'h00;
			else
				switch_on <= ctl_ff[`SSD_CTL_SW_HI:`SSD_CTL_SW_LO] & ~short_off_ff;
			if (ol_mode(ctl_ff))
				open_load_current <= ~ctl_ff[`SSD_CTL_SW_HI:`SSD_CTL_SW_LO];
			else
				open_load_current <= 6'h00;
			shutdown_delay_select <= {2{ctl_ff[`SSD_CTL_DELAY_SEL]}};
		end
	end

endmodule

// ==== tb/ssd_properties.sv ====
// Port assertions of the switch driver serial control
module ssd_props
#(
	parameter OV_LONG_CYC = 140000
)
(
	input wire       clk,
	input wire       sys_rst,
	input wire       chip_select_n,
	input wire       serial_clk,
	input wire       serial_data_in,
	input wire       serial_data_out,
	input wire       serial_data_oe,
	input wire       standby_pin_n,
	input wire       temp_prewarn,
	input wire       temp_shutdown,
	input wire       supply_fault,
	input wire [5:0] short_current,
	input wire [5:0] open_load_cmp,
	input wire [5:0] switch_on,
	input wire [5:0] open_load_current,
	input wire [1:0] shutdown_delay_select
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Checks
	logic [20:0] flt_cnt_ff;
	always @(posedge clk)
	begin
		if (sys_rst || !supply_fault)
			flt_cnt_ff <= 21'h00_0000;
		else if (flt_cnt_ff != 21'h1F_FFFF)
			flt_cnt_ff <= flt_cnt_ff + 21'h00_0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_reset_vals: assert property (
		$past(sys_rst) |-> switch_on == 6'h00 && shutdown_delay_select == 2'h3)
		else $error("reset values wrong");
	a_oe_idle: assert property (chip_select_n [*5] |-> !serial_data_oe)
		else $error("data out driven while deselected");
	a_oe_select: assert property (
		$fell(chip_select_n) ##1 !chip_select_n [*4] |-> serial_data_oe)
		else $error("data out not driven after select");
	a_apply_at_end: assert property (
		$changed(shutdown_delay_select) |-> $past(chip_select_n, 2))
		else $error("control applied inside frame");
	a_data_steady: assert property (
		(!serial_clk && !chip_select_n && serial_data_oe) [*2] |-> $stable(serial_data_out))
		else $error("data out moved without clock rise");
	a_no_test_on: assert property ((open_load_current & switch_on) == 6'h00)
		else $error("test current on a switched-on output");
	a_hot_off: assert property (temp_shutdown [*5] |-> switch_on == 6'h00)
		else $error("outputs on while overheated");
	a_supply_off: assert property (
		flt_cnt_ff > OV_LONG_CYC + 8 |-> switch_on == 6'h00)
		else $error("outputs on after supply delay");
	cover property ($fell(chip_select_n));
	cover property (flt_cnt_ff > OV_LONG_CYC);
	cover property (temp_shutdown && switch_on == 6'h00);
endmodule
bind ssd_serial_ctrl ssd_props #(.OV_LONG_CYC(OV_LONG_CYC)) i_ssd_props (.*);

// ==== tb/ssd_host_model.sv ====
// Host serial master model for the switch driver
module ssd_host_model
(
	input  wire  clk,
	output logic chip_select_n,
	output logic serial_clk,
	output logic serial_data_in,
	input  wire  serial_data_out,
	input  wire  serial_data_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Frame driver
	initial
	begin
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		serial_data_in = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] st);
		int n;
		st = 16'h0000;
		@(posedge clk) chip_select_n <= 1'b0;
		n = 0;
		while (serial_data_oe !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < nb; i++)
		begin
			@(posedge clk) serial_data_in <= w[i];
			serial_clk <= 1'b1;
			repeat (4) @(posedge clk);
			serial_clk <= 1'b0;
			repeat (3) @(posedge clk);
			@(negedge clk) st[i] = serial_data_out;
		end
		@(posedge clk) serial_data_in <= 1'b0;
		chip_select_n <= 1'b1;
		repeat (12) @(posedge clk);
	endtask
endmodule

// ==== tb/tb_top.sv ====
// Testbench of the switch driver serial control
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam OVL = 60;
	logic        clk, sys_rst, chip_select_n, serial_clk, serial_data_in, serial_data_out;
	logic        serial_data_oe, standby_pin_n, temp_prewarn, temp_shutdown, supply_fault;
	logic [5:0]  short_current, open_load_cmp, switch_on, open_load_current;
	logic [1:0]  shutdown_delay_select;
	logic [15:0] st;
	int          miscompares = 0;
	int          checks_done = 0;
	ssd_serial_ctrl #(.OV_LONG_CYC(OVL), .OV_SHORT_CYC(40), .SC_LONG_CYC(90),
		.SC_SHORT_CYC(50)) i_ssd_serial_ctrl (.*);
	ssd_host_model i_ssd_host_model (.*);
	// ==========================================
	// Clock, tasks, watchdog
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic sw(input logic [5:0] e);
		chk("switch_on", {10'h000, e}, {10'h000, switch_on});
	endtask
	task automatic wr(input logic [15:0] w);
		i_ssd_host_model.xfer(w, 16, st);
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
	// ==========================================
	// Tests
	initial
	begin
		sys_rst = 1'b1;
		standby_pin_n = 1'b1;
		temp_prewarn = 1'b0;
		temp_shutdown = 1'b0;
		supply_fault = 1'b0;
		short_current = 6'h00;
		open_load_cmp = 6'h00;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk);
		chk("delay", 16'h0003, {14'h0000, shutdown_delay_select});
		wr(16'hFFDA);
		chk("status", 16'h0000, st);
		sw(6'h2D);
		temp_prewarn <= 1'b1;
		i_ssd_host_model.xfer(16'h0000, 3, st);
		chk("prewarn", 16'h0001, {15'h0000, st[0]});
		sw(6'h2D);
		wr(16'hA000);
		chk("status", 16'h005B, st);
		chk("delay", 16'h0000, {14'h0000, shutdown_delay_select});
		temp_prewarn <= 1'b0;
		wr(16'h605A);
		sw(6'h00);
		wr(16'hE05A);
		chk("status", 16'h4000, st);
		standby_pin_n <= 1'b0;
		wr(16'hE05A);
		chk("status", 16'h4000, st);
		sw(6'h00);
		standby_pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		sw(6'h2D);
		open_load_cmp <= 6'h33;
		wr(16'hC00A);
		chk("ol_current", 16'h003A, {10'h000, open_load_current});
		wr(16'h400A);
		chk("status", 16'h006E, st);
		chk("ol_current", 16'h0000, {10'h000, open_load_current});
		open_load_cmp <= 6'h00;
		wr(16'hE05A);
		supply_fault <= 1'b1;
		repeat (OVL + 20) @(posedge clk);
		sw(6'h00);
		supply_fault <= 1'b0;
		repeat (6) @(posedge clk);
		sw(6'h2D);
		wr(16'hE05B);
		chk("status", 16'h805A, st);
		wr(16'hE05A);
		chk("status", 16'h005A, st);
		short_current <= 6'h01;
		repeat (100) @(posedge clk);
		sw(6'h2C);
		short_current <= 6'h00;
		wr(16'hE05A);
		chk("status", 16'h2058, st);
		wr(16'hE05B);
		sw(6'h2D);
		temp_shutdown <= 1'b1;
		repeat (8) @(posedge clk);
		sw(6'h00);
		wr(16'hE05A);
		chk("status", 16'hFFFF, st);
		temp_shutdown <= 1'b0;
		repeat (6) @(posedge clk);
		sw(6'h00);
		wr(16'hE05B);
		sw(6'h2D);
		give_verdict();
	end
endmodule
